// File: bench/teqg_enc_model.sv
// Purpose: behavioural trace encoder taking elements in offered order
// Assumes: one element per accepting edge
// Notes:   stalls at random so held elements are exercised
`default_nettype none
module teqg_enc_model
(
  input  wire logic clk,        // clock
  input  wire logic rst_n,      // reset, low
  input  wire logic elem_valid, // element offered
  output var  logic elem_ready  // element accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  // stall about a quarter of offered cycles; nothing is reordered
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      elem_ready <= 1'b0;
    else
      elem_ready <= elem_valid ? ($urandom % 4 != 0) : 1'b1;
endmodule
`default_nettype wire

// File: bench/teqg_monitor.sv
// Purpose: port checker for the trace element generator
// Assumes: element handed over on elem_valid_ff and elem_ready
// Notes:   bound to every generator instance
`default_nettype none
`include "teqg_defines.vh"
module teqg_monitor
(
  input wire logic                    clk,                     // clock
  input wire logic                    rst_n,                   // reset, low
  input wire logic                    ret_valid,               // retire valid
  input wire logic                    ret_ready_ff,            // retire ready
  input wire logic [`TEQG_KIND_W-1:0] ret_kind,                // requested kind
  input wire logic [`TEQG_EXC_W-1:0]  ret_exc_type,            // exception type
  input wire logic                    ret_imprecise,           // imprecise
  input wire logic [`TEQG_VA_W-1:0]   exception_link_register, // link value
  input wire logic [`TEQG_VA_W-1:0]   debug_link_register,     // debug link
  input wire logic                    elem_ready,              // encoder ready
  input wire logic                    elem_valid_ff,           // element valid
  input wire logic [`TEQG_KIND_W-1:0] elem_kind_ff,            // element kind
  input wire logic [`TEQG_EXC_W-1:0]  elem_exc_ff,             // exception type
  input wire logic [`TEQG_VA_W-1:0]   elem_addr_ff,            // address
  input wire logic                    elem_addr_unk_ff,        // address unknown
  input wire logic                    elem_ctx_unk_ff,         // context unknown
  input wire logic                    elem_cnt_vld_ff,         // count valid
  input wire logic [`TEQG_CNT_W-1:0]  elem_cnt_ff,             // count
  input wire logic                    elem_is_p0_ff,           // p0 group
  input wire logic                    txn_start_is_p0_flag,    // id field
  input wire logic [`TEQG_PTR_W:0]    spec_depth_ff            // unresolved p0
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic take;
  // a retire event is taken when both sides agree
  assign take = ret_valid && ret_ready_ff && (!elem_valid_ff || elem_ready) &&
                !spec_depth_ff[`TEQG_PTR_W];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_src_answer;
    take && ret_kind == `TEQG_K_SRC_ADDR |=> elem_valid_ff && elem_kind_ff == `TEQG_K_SRC_ADDR;
  endproperty
  a_src_answer: assert property (p_src_answer) else $error("source element missing");
  property p_stand;
    elem_valid_ff && !elem_ready |=> elem_valid_ff && $stable(elem_addr_ff) && $stable(elem_kind_ff);
  endproperty
  a_stand: assert property (p_stand) else $error("element changed while stalled");
  property p_syserr;
    take && ret_kind == `TEQG_K_EXCEPTION && ret_exc_type == `TEQG_E_SYS_ERROR && ret_imprecise
      |=> elem_addr_ff == $past(exception_link_register);
  endproperty
  a_syserr: assert property (p_syserr) else $error("system error address wrong");
  property p_dbg;
    take && ret_kind == `TEQG_K_EXCEPTION && ret_exc_type == `TEQG_E_DEBUG_HALT && ret_imprecise
      |=> elem_addr_ff == $past(debug_link_register);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug halt address wrong");
  property p_q_refuse;
    take && ret_kind == `TEQG_K_Q && ret_exc_type != 4'h0 |=> !$rose(elem_valid_ff);
  endproperty
  a_q_refuse: assert property (p_q_refuse) else $error("q element carried exception");
  property p_reset_elem;
    elem_valid_ff && elem_kind_ff == `TEQG_K_EXCEPTION && elem_exc_ff == `TEQG_E_PE_RESET
      |-> elem_addr_unk_ff && elem_ctx_unk_ff && elem_cnt_vld_ff && elem_cnt_ff == 16'h0;
  endproperty
  a_reset_elem: assert property (p_reset_elem) else $error("reset element fields wrong");
  property p_p0;
    elem_valid_ff && elem_kind_ff inside {`TEQG_K_EXCEPTION, `TEQG_K_SRC_ADDR, `TEQG_K_Q}
      |-> elem_is_p0_ff;
  endproperty
  a_p0: assert property (p_p0) else $error("p0 element not marked p0");
  property p_flag;
    elem_valid_ff && elem_kind_ff == `TEQG_K_TXN_START |-> elem_is_p0_ff == txn_start_is_p0_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("txn start class differs from flag");
endmodule
bind teqg_gen teqg_monitor u_mon (.*);
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the trace element generator
// Assumes: notes of expected elements are matched in offered order
// Notes:   commits drain the speculation window between groups
`default_nettype none
`include "teqg_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] k; logic [3:0] e; logic [63:0] a; logic [1:0] i;
    logic ca; logic cv; logic [15:0] c;} teqg_exp_t;
  logic clk = 0, rst_n = 0, ret_valid = 0, ret_imprecise = 0, ret_cnt_known = 0;
  logic ret_eret_taken = 0, ret_barrier_new = 0, ret_ctx_change = 0, ctx_before_tgt = 0;
  logic warm_reset_pulse = 0, impdef_en = 0, commit_req = 0, cancel_req = 0;
  logic [3:0]  ret_kind = 4'h0, ret_exc_type = 4'h0;
  logic [1:0]  ret_isa = 2'h0;
  logic [15:0] ret_cnt = 16'h0, rnd_cnt;
  logic [63:0] ret_addr = 64'h0, exception_link_register = 64'h0, debug_link_register = 64'h0;
  logic [63:0] rnd_addr;
  wire logic        elem_ready, ret_ready_ff, elem_valid_ff, elem_addr_unk_ff, elem_ctx_unk_ff;
  wire logic        elem_cnt_vld_ff, elem_is_p0_ff, txn_start_is_p0_flag;
  wire logic [3:0]  elem_kind_ff, elem_exc_ff, oldest_kind_ff;
  wire logic [63:0] elem_addr_ff;
  wire logic [1:0]  elem_isa_ff;
  wire logic [15:0] elem_cnt_ff;
  wire logic [4:0]  spec_depth_ff;
  teqg_exp_t expq[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  teqg_gen DUT (.*);
  teqg_enc_model u_enc (.clk(clk), .rst_n(rst_n), .elem_valid(elem_valid_ff), .elem_ready(elem_ready));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    cmp_count++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic chk_elem(input teqg_exp_t x);
    chk("kind", 64'(x.k), 64'(elem_kind_ff));
    if (x.ca)
    begin
      chk("addr", x.a, elem_addr_ff);
      chk("isa", 64'(x.i), 64'(elem_isa_ff));
    end
    if (x.k == `TEQG_K_Q || x.e == `TEQG_E_PE_RESET)
      chk("cnt", 64'({x.cv, x.c}), 64'({elem_cnt_vld_ff, x.cv ? elem_cnt_ff : x.c}));
    if (x.k == `TEQG_K_EXCEPTION)
      chk("exc", 64'({x.e, {2{x.e == `TEQG_E_PE_RESET}}}),
          64'({elem_exc_ff, elem_addr_unk_ff, elem_ctx_unk_ff}));
    if (x.k != `TEQG_K_CONTEXT && x.k != `TEQG_K_TGT_ADDR)
      chk("p0", 64'(x.k == `TEQG_K_TXN_START ? `TEQG_TXN_P0_DFLT : 1'b1),
          64'(elem_is_p0_ff));
  endtask
  function automatic void ex(input logic [3:0] k, e, input logic [63:0] a, input logic [1:0] i,
                             input logic ca, cv, input logic [15:0] c);
    expq.push_back(teqg_exp_t'{k, e, a, i, ca, cv, c});
  endfunction
  // hold the request until the edge that takes it, then drop it for one cycle
  task automatic ev(input logic [3:0] k, e, input logic [63:0] a, input logic [1:0] i,
                    input logic [4:0] f, input logic [15:0] c);
    int n;
    n = 0;
    ret_valid <= 1'b1;
    ret_kind <= k;
    ret_exc_type <= e;
    ret_addr <= a;
    ret_isa <= i;
    ret_imprecise <= 1'b1;
    ret_cnt <= c;
    {ret_cnt_known, ret_eret_taken, ret_barrier_new, ret_ctx_change, ctx_before_tgt} <= f;
    @(posedge clk);
    while (!(ret_ready_ff === 1'b1 && (elem_valid_ff !== 1'b1 || elem_ready === 1'b1) &&
             spec_depth_ff < 5'h10) && n < 60)
    begin
      n++;
      @(posedge clk);
    end
    chk("taken", 64'h0, 64'(n == 60));
    ret_valid <= 1'b0;
    @(posedge clk);
  endtask
  // commit everything once all notes are matched
  task automatic drain;
    for (int n = 0; n < 200 && expq.size() != 0; n++)
      @(posedge clk);
    repeat (40)
    begin
      commit_req <= spec_depth_ff != 5'h0;
      @(posedge clk);
    end
    commit_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk("depth", 64'h0, 64'(spec_depth_ff));
  endtask
  // oldest note against each accepted element; commit and cancel kinds are not noted
  always @(posedge clk)
    if (rst_n && elem_valid_ff === 1'b1 && elem_ready === 1'b1 && elem_kind_ff < `TEQG_K_COMMIT)
    begin
      if (expq.size() == 0)
        chk("extra element", 64'h0, 64'(elem_kind_ff));
      else
        chk_elem(expq.pop_front());
    end
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  initial
  begin
    void'($urandom(17));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    exception_link_register <= {$urandom, $urandom};
    debug_link_register <= {$urandom, $urandom};
    repeat (2) @(posedge clk);
    chk("flag", 64'(`TEQG_TXN_P0_DFLT), 64'(txn_start_is_p0_flag));
    for (int i = 0; i < 3; i++)
    begin
      rnd_addr = {$urandom, $urandom};
      ex(`TEQG_K_SRC_ADDR, 0, rnd_addr, 2'(i), 1, 0, 0);
      ev(`TEQG_K_SRC_ADDR, 0, rnd_addr, 2'(i), 5'h0, 16'h0);
    end
    rnd_cnt = 16'($urandom);
    ex(`TEQG_K_Q, 0, 0, 0, 0, 1, rnd_cnt);
    ev(`TEQG_K_Q, 0, 0, 0, 5'h10, rnd_cnt);
    ex(`TEQG_K_Q, 0, 0, 0, 0, 0, 0);
    ev(`TEQG_K_Q, 0, 0, 0, 5'h08, 16'h0);
    drain;
    $display("test source and q done");
    ex(`TEQG_K_EXCEPTION, `TEQG_E_SYS_ERROR, exception_link_register, 1, 1, 0, 0);
    ev(`TEQG_K_EXCEPTION, `TEQG_E_SYS_ERROR, 64'h4, 2'h1, 5'h0, 16'h0);
    ex(`TEQG_K_EXCEPTION, `TEQG_E_DEBUG_HALT, debug_link_register, 2, 1, 0, 0);
    ev(`TEQG_K_EXCEPTION, `TEQG_E_DEBUG_HALT, 64'h8, 2'h2, 5'h0, 16'h0);
    impdef_en <= 1'b1;
    rnd_addr = {$urandom, $urandom};
    ex(`TEQG_K_EXCEPTION, `TEQG_E_IMPDEF, rnd_addr, 0, 1, 0, 0);
    ev(`TEQG_K_EXCEPTION, `TEQG_E_IMPDEF, rnd_addr, 2'h0, 5'h0, 16'h0);
    impdef_en <= 1'b0;
    ev(`TEQG_K_EXCEPTION, `TEQG_E_IMPDEF, rnd_addr, 2'h0, 5'h0, 16'h0);
    ev(`TEQG_K_Q, `TEQG_E_SYS_ERROR, 64'h0, 2'h0, 5'h0, 16'h0);
    ex(`TEQG_K_TXN_START, 0, 0, 0, 0, 0, 0);
    ev(`TEQG_K_TXN_START, 0, 64'h0, 2'h0, 5'h0, 16'h0);
    while (ret_ready_ff !== 1'b1)
      @(posedge clk);
    ex(`TEQG_K_EXCEPTION, `TEQG_E_PE_RESET, 0, 0, 0, 1, 0);
    warm_reset_pulse <= 1'b1;
    @(posedge clk);
    warm_reset_pulse <= 1'b0;
    drain;
    $display("test exceptions done");
    for (int b = 0; b < 4; b++)
    begin
      ex(`TEQG_K_Q, 0, 0, 0, 0, 0, 0);
      ex(b[0] ? `TEQG_K_CONTEXT : `TEQG_K_TGT_ADDR, 0, 0, 0, 0, 0, 0);
      ex(b[0] ? `TEQG_K_TGT_ADDR : `TEQG_K_CONTEXT, 0, 0, 0, 0, 0, 0);
      ev(`TEQG_K_Q, 0, 64'h0, 2'h0, {2'b00, !b[1], b[1], b[0]}, 16'h0);
    end
    drain;
    ex(`TEQG_K_SRC_ADDR, 0, 64'h40, 1, 1, 0, 0);
    ev(`TEQG_K_SRC_ADDR, 0, 64'h40, 2'h1, 5'h0, 16'h0);
    repeat (30) @(posedge clk);
    chk("depth", 64'h1, 64'(spec_depth_ff));
    chk("oldest", 64'(`TEQG_K_SRC_ADDR), 64'(oldest_kind_ff));
    cancel_req <= 1'b1;
    @(posedge clk);
    cancel_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("depth", 64'h0, 64'(spec_depth_ff));
    $display("test context follow-ups and cancel done");
    results();
  end
endmodule
`default_nettype wire

// File: src/teqg_defines.vh
// Purpose: constants for the trace exception / Q element generator
// Assumes: 64-bit virtual addresses, 125 MHz processor clock
// Notes:   element kind and isa codes are fixed encodings on the element port
`ifndef TEQG_DEFINES_VH
`define TEQG_DEFINES_VH
`define TEQG_VA_W          64
`define TEQG_CNT_W         16
`define TEQG_KIND_W        4
`define TEQG_EXC_W         4
`define TEQG_ISA_W         2
`define TEQG_DEPTH         16
`define TEQG_PTR_W         4
`define TEQG_ELEM_W        92
// element kinds
`define TEQG_K_EXCEPTION   4'h1
`define TEQG_K_SRC_ADDR    4'h2
`define TEQG_K_Q           4'h3
`define TEQG_K_CONTEXT     4'h4
`define TEQG_K_TGT_ADDR    4'h5
`define TEQG_K_TXN_START   4'h6
`define TEQG_K_COMMIT      4'h7
`define TEQG_K_CANCEL      4'h8
// exception types
`define TEQG_E_SYS_ERROR   4'h1
`define TEQG_E_DEBUG_HALT  4'h2
`define TEQG_E_PE_RESET    4'h3
`define TEQG_E_IMPDEF      4'h4
// instruction set codes
`define TEQG_ISA_WIDE      2'h0
`define TEQG_ISA_CLASSIC   2'h1
`define TEQG_ISA_COMPACT   2'h2
`define TEQG_ISA_UNKNOWN   2'h3
// identification strap default: transaction start counts as p0
`define TEQG_TXN_P0_DFLT   1'b1
`endif

// File: src/teqg_gen.v
// Purpose: generates exception, source address, q, context and txn start
//          elements in program order for the trace encoder
// Assumes: retire events arrive in program order, at most one per cycle
// Notes:   encoder must accept elements (elem_ready) or retire stalls
// Operation
// [R1] imprecise system error reports exception link register value at take.
// [R2] imprecise debug halt reports debug link register value at take.
// [R3] system error reach is implementation defined; address passed as given.
// [R4] warm reset of the processing element emits a reset exception element.
// [R5] reset element: unknown address and context, no instructions implied.
// [R6] implementation defined exceptions traced only when enabled.
// [R7] implementation defined return address is instruction after last executed.
// [R8] source address: reached and included p0 instruction, taken; earlier not.
// [R9] source address carries final p0 address and one of three isa.
// [R10] source address counts as a p0 element.
// [R11] q element is p0 and must later be resolved or cancelled.
// [R12] q element optionally carries instruction count since last p0.
// [R13] q elements emitted in program order; encoder keeps order.
// [R14] exceptions never conveyed by q elements.
// [R15] taken exception return ends the q element.
// [R16] barrier followed by new context ends the q element.
// [R17] new context after q element emits a context element.
// [R18] context element may come before or after target address.
// [R19] unsynchronised context change ends q at last old-context instruction.
// [R20] identification flag states whether txn start is p0; classify to match.
// [R21] all p0 elements speculative, later committed or cancelled.
// [R22] p0 elements emitted in simple sequential execution order.
// [R23] isa attribute uses three fixed codes for all element kinds; the reset element carries a fourth code, TEQG_ISA_UNKNOWN.
`default_nettype none
`include "teqg_defines.vh"
module teqg_gen
(
  input  wire                      clk,             // processor clock
  input  wire                      rst_n,           // async reset, active low
  input  wire                      ret_valid,       // retire event valid
  input  wire [`TEQG_KIND_W-1:0]   ret_kind,        // requested element kind
  input  wire [`TEQG_EXC_W-1:0]    ret_exc_type,    // exception type
  input  wire                      ret_imprecise,   // exception is imprecise
  input  wire [`TEQG_VA_W-1:0]     ret_addr,        // instr va / return address
  input  wire [1:0]                ret_isa,         // 0 wide,1 classic,2 compact
  input  wire                      ret_cnt_known,   // q count supplied
  input  wire [`TEQG_CNT_W-1:0]    ret_cnt,         // q instruction count
  input  wire                      ret_eret_taken,  // q ends at taken eret
  input  wire                      ret_barrier_new, // q ends at barrier, new ctx
  input  wire                      ret_ctx_change,  // unsynchronised ctx change
  input  wire                      ctx_before_tgt,  // context before target addr
  input  wire [`TEQG_VA_W-1:0]     exception_link_register, // link reg value
  input  wire [`TEQG_VA_W-1:0]     debug_link_register,     // debug link value
  input  wire                      warm_reset_pulse, // pe warm reset event
  input  wire                      impdef_en,       // trace impdef exceptions
  input  wire                      commit_req,      // commit oldest p0
  input  wire                      cancel_req,      // cancel youngest p0
  input  wire                      elem_ready,      // encoder accepts element
  output reg                       ret_ready_ff,    // block accepts retire event
  output reg                       elem_valid_ff,   // element valid
  output reg  [`TEQG_KIND_W-1:0]   elem_kind_ff,    // element kind
  output reg  [`TEQG_EXC_W-1:0]    elem_exc_ff,     // exception type
  output reg  [`TEQG_VA_W-1:0]     elem_addr_ff,    // address field
  output reg  [1:0]                elem_isa_ff,     // isa code
  output reg                       elem_addr_unk_ff, // address unknown
  output reg                       elem_ctx_unk_ff, // context unknown
  output reg                       elem_cnt_vld_ff, // count field valid
  output reg  [`TEQG_CNT_W-1:0]    elem_cnt_ff,     // q instruction count
  output reg                       elem_is_p0_ff,   // element is in p0 group
  output reg                       txn_start_is_p0_flag, // id field, read only
  output reg  [`TEQG_PTR_W:0]      spec_depth_ff,   // unresolved p0 count
  output reg  [`TEQG_KIND_W-1:0]   oldest_kind_ff   // kind of oldest p0
);
  // state machine, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EMIT = 3'b010;
  localparam [2:0] ST_CTX  = 3'b100;

  reg [2:0]                 st_ff;
  reg [2:0]                 nxt_st;
  reg                       strap_done_ff;
  reg                       pend_ctx_ff;
  reg                       pend_tgt_ff;
  reg                       rst_pend_ff;
  reg                       ctx_first_ff;
  reg [`TEQG_KIND_W-1:0]    wr_kind;
  reg                       wr_en;
  reg [`TEQG_PTR_W-1:0]     head_ff;
  reg [`TEQG_PTR_W-1:0]     tail_ff;
  wire [`TEQG_KIND_W-1:0]   mem_rd;

  // decide membership in the p0 group
  function is_p0;
    input [`TEQG_KIND_W-1:0] k;
    input                    txn_p0;
    begin
      case (k)
        `TEQG_K_EXCEPTION: is_p0 = 1'b1; // R21
        `TEQG_K_SRC_ADDR:  is_p0 = 1'b1; // R10
        `TEQG_K_Q:         is_p0 = 1'b1; // R11
        `TEQG_K_TXN_START: is_p0 = txn_p0; // R20
        default:           is_p0 = 1'b0;
      endcase
    end
  endfunction

  // map isa input to the fixed code, anything else is unknown
  function [1:0] isa_code;
    input [1:0] i;
    begin
      case (i)
        2'h0:    isa_code = `TEQG_ISA_WIDE;    // R23
        2'h1:    isa_code = `TEQG_ISA_CLASSIC; // R23
        2'h2:    isa_code = `TEQG_ISA_COMPACT; // R23
        default: isa_code = `TEQG_ISA_UNKNOWN;
      endcase
    end
  endfunction

  wire out_free   = ~elem_valid_ff | elem_ready;
  // exceptions requested as q are refused, never mapped into q
  wire bad_q      = (ret_kind == `TEQG_K_Q) && (ret_exc_type != 4'h0); // R14
  wire impdef_drop = (ret_kind == `TEQG_K_EXCEPTION) &&
                     (ret_exc_type == `TEQG_E_IMPDEF) && ~impdef_en; // R6
  wire full       = spec_depth_ff[`TEQG_PTR_W];
  // a retire is only taken when its element can leave in the same cycle
  wire take_ret   = ret_valid && ret_ready_ff && (st_ff == ST_IDLE) && out_free && ~full;
  wire emit_ret   = take_ret && ~bad_q && ~impdef_drop;
  // a warm reset pulse is held pending until its element can go out
  wire rst_want   = warm_reset_pulse | rst_pend_ff; // R4
  wire rst_emit   = rst_want && out_free && (st_ff == ST_IDLE) && ~take_ret && ~full;
  wire spec_push  = wr_en;
  wire spec_pop   = commit_req && (spec_depth_ff != 5'h00);
  wire spec_cut   = cancel_req && ~spec_pop && (spec_depth_ff != 5'h00);
  // a cancel meeting a push frees the youngest slot, so the new record reuses it
  wire [`TEQG_PTR_W-1:0] wr_slot = spec_cut ? (tail_ff - 4'h1) : tail_ff; // R21

  teqg_spec_mem u_mem
  (
    .clk        (clk),
    .wr_en      (wr_en),
    .wr_addr    (wr_slot),
    .wr_data    (wr_kind),
    .rd_addr    (head_ff),
    .rd_data_ff (mem_rd)
  );

  // next state: q closing a context needs a context element too
  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (emit_ret && out_free && (ret_kind == `TEQG_K_Q) &&
            (ret_barrier_new || ret_ctx_change)) // R17
          nxt_st = ST_CTX;
      ST_CTX:
        if (out_free)
          nxt_st = ST_EMIT;
      ST_EMIT:
        if (out_free)
          nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // speculation record written for each p0 element emitted, reset element too
  always @*
  begin
    wr_en   = (emit_ret && is_p0(ret_kind, txn_start_is_p0_flag)) || rst_emit; // R21
    wr_kind = rst_emit ? `TEQG_K_EXCEPTION : ret_kind;
  end

  // strap the id flag once after reset release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txn_start_is_p0_flag <= 1'b0;
      strap_done_ff        <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      txn_start_is_p0_flag <= `TEQG_TXN_P0_DFLT; // R20
      strap_done_ff        <= 1'b1;
    end
  end

  // speculation depth and pointers; commit from head, cancel from tail
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_ff       <= 4'h0;
      tail_ff       <= 4'h0;
      spec_depth_ff <= 5'h00;
      oldest_kind_ff <= 4'h0;
    end
    else
    begin
      oldest_kind_ff <= mem_rd;
      if (spec_push && !spec_cut)
        tail_ff <= tail_ff + 4'h1;
      else if (spec_cut && !spec_push)
        tail_ff <= tail_ff - 4'h1; // R21
      if (spec_pop)
        head_ff <= head_ff + 4'h1; // R21
      if (spec_push && !(spec_pop || spec_cut))
        spec_depth_ff <= spec_depth_ff + 5'h01;
      else if (!spec_push && (spec_pop || spec_cut))
        spec_depth_ff <= spec_depth_ff - 5'h01;
    end
  end

  // main sequencer and element output register
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff            <= ST_IDLE;
      ret_ready_ff     <= 1'b0;
      elem_valid_ff    <= 1'b0;
      elem_kind_ff     <= 4'h0;
      elem_exc_ff      <= 4'h0;
      elem_addr_ff     <= 64'h0000000000000000;
      elem_isa_ff      <= 2'h0;
      elem_addr_unk_ff <= 1'b0;
      elem_ctx_unk_ff  <= 1'b0;
      elem_cnt_vld_ff  <= 1'b0;
      elem_cnt_ff      <= 16'h0000;
      elem_is_p0_ff    <= 1'b0;
      pend_ctx_ff      <= 1'b0;
      pend_tgt_ff      <= 1'b0;
      rst_pend_ff      <= 1'b0;
      ctx_first_ff     <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      // stall retire while busy, record full or a warm reset still owed
      ret_ready_ff <= (nxt_st == ST_IDLE) && ~full && ~rst_want;
      // a pulse meeting the emission of an older one stays pending
      rst_pend_ff  <= warm_reset_pulse ? (rst_pend_ff | ~rst_emit) : (rst_pend_ff & ~rst_emit);
      if (elem_ready)
        elem_valid_ff <= 1'b0;
      // a retire taken this cycle goes first; the reset waits for its element and any context/target follow-ups
      if (rst_emit)
      begin
        elem_valid_ff    <= 1'b1;
        elem_kind_ff     <= `TEQG_K_EXCEPTION; // R4
        elem_exc_ff      <= `TEQG_E_PE_RESET;  // R4
        elem_addr_ff     <= 64'h0000000000000000;
        elem_isa_ff      <= `TEQG_ISA_UNKNOWN;
        elem_addr_unk_ff <= 1'b1; // R5
        elem_ctx_unk_ff  <= 1'b1; // R5
        elem_cnt_vld_ff  <= 1'b1; // R5
        elem_cnt_ff      <= 16'h0000; // R5
        elem_is_p0_ff    <= 1'b1;
      end
      else if (emit_ret && out_free)
      begin
        elem_valid_ff    <= 1'b1; // R22
        elem_kind_ff     <= ret_kind; // R13
        elem_exc_ff      <= ret_exc_type;
        elem_isa_ff      <= isa_code(ret_isa); // R9
        elem_addr_unk_ff <= 1'b0;
        elem_ctx_unk_ff  <= 1'b0;
        elem_cnt_vld_ff  <= (ret_kind == `TEQG_K_Q) && ret_cnt_known; // R12
        elem_cnt_ff      <= ret_cnt; // R12
        elem_is_p0_ff    <= is_p0(ret_kind, txn_start_is_p0_flag);
        // preferred return address selection
        if (ret_kind == `TEQG_K_EXCEPTION && ret_imprecise &&
            ret_exc_type == `TEQG_E_SYS_ERROR)
          elem_addr_ff <= exception_link_register; // R1 R3
        else if (ret_kind == `TEQG_K_EXCEPTION && ret_imprecise &&
                 ret_exc_type == `TEQG_E_DEBUG_HALT)
          elem_addr_ff <= debug_link_register; // R2
        else
          elem_addr_ff <= ret_addr; // R7 R8
        // q with barrier or ctx change closes here, follow-ups queued; eret only sets pend_tgt_ff
        pend_ctx_ff <= (ret_kind == `TEQG_K_Q) &&
                       (ret_barrier_new || ret_ctx_change); // R15 R16 R19
        pend_tgt_ff <= (ret_kind == `TEQG_K_Q) &&
                       (ret_barrier_new || ret_ctx_change || ret_eret_taken);
        // order of the follow-up pair is fixed at the q, inputs may move on
        ctx_first_ff <= ctx_before_tgt; // R18
      end
      else if (st_ff == ST_CTX && out_free)
      begin
        // first follow-up: context or target, per ordering choice
        elem_valid_ff    <= 1'b1;
        elem_kind_ff     <= ctx_first_ff ? `TEQG_K_CONTEXT : `TEQG_K_TGT_ADDR; // R18
        elem_cnt_vld_ff  <= 1'b0;
        elem_is_p0_ff    <= 1'b0;
      end
      else if (st_ff == ST_EMIT && out_free)
      begin
        // second follow-up completes the pair
        elem_valid_ff    <= 1'b1;
        elem_kind_ff     <= ctx_first_ff ? `TEQG_K_TGT_ADDR : `TEQG_K_CONTEXT; // R17
        elem_cnt_vld_ff  <= 1'b0;
        elem_is_p0_ff    <= 1'b0;
        pend_ctx_ff      <= 1'b0;
        pend_tgt_ff      <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/teqg_spec_mem.v
// Purpose: small register-file memory of speculative p0 element kinds
// Assumes: one write and one read port, single clock
// Notes:   read data is registered, one cycle latency
`default_nettype none
`include "teqg_defines.vh"
module teqg_spec_mem
(
  input  wire                     clk,      // processor clock
  input  wire                     wr_en,    // write strobe
  input  wire [`TEQG_PTR_W-1:0]   wr_addr,  // write slot
  input  wire [`TEQG_KIND_W-1:0]  wr_data,  // element kind
  input  wire [`TEQG_PTR_W-1:0]   rd_addr,  // read slot
  output reg  [`TEQG_KIND_W-1:0]  rd_data_ff // registered read data
);
  reg [`TEQG_KIND_W-1:0] mem [0:`TEQG_DEPTH-1];

  // write port, no reset needed on storage
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // registered read port
  always @(posedge clk)
  begin
    rd_data_ff <= mem[rd_addr];
  end
endmodule
`default_nettype wire
